/* logic/sfe_pkg.sv */
// Purpose: Shared constants for the serial flash erase and power-down link.
// Assumes: Both ends run from the same 40 MHz reference clock rate.
// Notes: Erase and power-down times are plain defaults and are shortened in simulation.
package sfe_pkg;
   localparam int          CLK_PERIOD_NS   = 25;
   localparam int          ADDR_W          = 24;
   localparam int          OP_BITS         = 8;
   localparam int          ADDR_CMD_BITS   = 32;
   localparam int          RDSR_CMD_BITS   = 16;
   localparam int          BLK32_LSB       = 15;
   localparam int          BLK64_LSB       = 16;
   localparam int          NUM_BLK32       = 512;
   localparam int          STS_WIP         = 0;
   localparam int          STS_WEL         = 1;
   localparam logic [7:0]  OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0]  OP_READ_STATUS  = 8'h05;
   localparam logic [7:0]  OP_ERASE_32K    = 8'h52;
   localparam logic [7:0]  OP_ERASE_64K    = 8'hD8;
   localparam logic [7:0]  OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0]  OP_CHIP_ERASE_B = 8'hC7;
   localparam logic [7:0]  OP_POWER_DOWN   = 8'hB9;
   localparam logic [7:0]  OP_RELEASE_PD   = 8'hAB;
   localparam logic [2:0]  BP_NONE         = 3'h0;
   localparam logic [2:0]  BP_ALL          = 3'h7;
   localparam logic [8:0]  BLK64_COUNT     = 9'h100;
   localparam int          T_BE32_NS       = 200000;
   localparam int          T_BE64_NS       = 300000;
   localparam int          T_CE_NS         = 1000000;
   localparam int          T_DP_NS         = 3000;
   localparam int          T_RES_NS        = 3000;
   localparam int          SCK_HALF_CYC    = 4;
   localparam int          GAP_CYC         = 4;

   // Least times round up to whole clock cycles.
   function automatic int ns_to_cyc(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction : ns_to_cyc

   localparam int BE32_CYC = ns_to_cyc(T_BE32_NS);
   localparam int BE64_CYC = ns_to_cyc(T_BE64_NS);
   localparam int CE_CYC   = ns_to_cyc(T_CE_NS);
   localparam int DP_CYC   = ns_to_cyc(T_DP_NS);
   localparam int RES_CYC  = ns_to_cyc(T_RES_NS);

   function automatic logic is_block_erase(input logic [7:0] op);
      return (op == OP_ERASE_32K) || (op == OP_ERASE_64K);
   endfunction : is_block_erase

   function automatic logic is_chip_erase(input logic [7:0] op);
      return (op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B);
   endfunction : is_chip_erase

   // Low protect bits give no 64KB blocks (code 0) or a power-of-two count of them, top or bottom; the complement inverts it.
   function automatic logic blk_protected(input logic [7:0] blk, input logic [4:0] bp, input logic cmp);
      logic [8:0] n;
      logic       hit;
      n   = (bp[2:0] == BP_ALL) ? BLK64_COUNT : 9'((9'h001 << bp[2:0]) >> 1);
      hit = bp[3] ? ({1'b0, blk} < n) : ({1'b0, blk} >= 9'(BLK64_COUNT - n));
      return hit ^ cmp;
   endfunction : blk_protected
endpackage : sfe_pkg

/* logic/sfe_spi_if.sv */
// Purpose: Serial link between the flash controller and the flash device.
// Assumes: The data-out line is pulled high when the device does not drive it.
// Notes: The controller makes chip select, serial clock and serial input.
`timescale 1ns/1ps
interface sfe_spi_if;
   logic cs_n;
   logic sclk;
   logic mosi;
   logic miso_drv;
   logic miso_oe;
   logic miso;

   assign miso = miso_oe ? miso_drv : 1'b1;

   modport dev  (input cs_n, input sclk, input mosi, output miso_drv, output miso_oe);
   modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : sfe_spi_if

/* logic/sfe_flash_dev.sv */
// Purpose: Erase and deep power-down command handling inside the serial flash.
// Assumes: Link pins are asynchronous to ref_clk_in and are oversampled.
// Notes:
`timescale 1ns/1ps
module sfe_flash_dev #(
   parameter int BE32_CYC = sfe_pkg::BE32_CYC,
   parameter int BE64_CYC = sfe_pkg::BE64_CYC,
   parameter int CE_CYC   = sfe_pkg::CE_CYC,
   parameter int DP_CYC   = sfe_pkg::DP_CYC,
   parameter int RES_CYC  = sfe_pkg::RES_CYC
) (
   input  wire logic                       ref_clk_in,
   input  wire logic                       rst_in,
   sfe_spi_if.dev                          spi,
   input  wire logic [4:0]                 protect_bits_in,
   input  wire logic                       protect_complement_in,
   input  wire logic [sfe_pkg::ADDR_W-1:0] query_addr_in,
   output logic                            query_erased_out,
   output logic                            write_in_progress_out,
   output logic                            write_enable_latch_out,
   output logic                            deep_power_down_out
);
   import sfe_pkg::*;

   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_ERASING,
      ST_DP_ENTRY,
      ST_DEEP_PD,
      ST_RELEASING
   } sfe_dev_state_e;

   logic [2:0]           s1_ff;
   logic [2:0]           s2_ff;
   logic [2:0]           pv_ff;
   logic                 sel;
   logic                 cs_rise;
   logic                 sck_rise;
   logic                 sck_fall;
   logic [5:0]           cnt_ff;
   logic [31:0]          shift_ff;
   logic [7:0]           op_ff;
   logic [2:0]           rbit_ff;
   logic                 miso_ff;
   logic                 moe_ff;
   sfe_dev_state_e       st_ff;
   sfe_dev_state_e       nxt_st;
   logic [31:0]          tmr_ff;
   logic                 tmr_zero;
   logic                 wel_ff;
   logic                 blk64_ff;
   logic                 chip_ff;
   logic [8:0]           blk_ff;
   logic [NUM_BLK32-1:0] map_ff;
   logic                 idle;
   logic                 at_op;
   logic                 at_addr;
   logic                 chip_ok;
   logic                 go_write_enable_cmd;
   logic                 go_blk;
   logic                 go_chip;
   logic                 go_dp;
   logic                 go_rel;
   logic                 erase_end;
   logic [7:0]           sts;

   assign spi.miso_drv = miso_ff;
   assign spi.miso_oe  = moe_ff;

   // Pin order in the sampler is {serial input, serial clock, chip select}.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s1_ff <= 3'h7;
         s2_ff <= 3'h7;
         pv_ff <= 3'h7;
      end else begin
         s1_ff <= {spi.mosi, spi.sclk, spi.cs_n};
         s2_ff <= s1_ff;
         pv_ff <= s2_ff;
      end
   end

   always_comb begin
      sel       = ~s2_ff[0];
      cs_rise   = s2_ff[0] & ~pv_ff[0];
      sck_rise  = sel & s2_ff[1] & ~pv_ff[1];
      sck_fall  = sel & ~s2_ff[1] & pv_ff[1];
      idle      = (st_ff == ST_STANDBY);
      at_op     = (cnt_ff == 6'(OP_BITS));
      at_addr   = (cnt_ff == 6'(ADDR_CMD_BITS));
      tmr_zero  = (tmr_ff == 32'h0);
      erase_end = (st_ff == ST_ERASING) & tmr_zero;
      chip_ok   = ({protect_bits_in[2:0], protect_complement_in} == 4'h0)
                | ({protect_bits_in[2:0], protect_complement_in} == 4'hF);
      sts          = 8'h00;
      sts[STS_WIP] = (st_ff == ST_ERASING);
      sts[STS_WEL] = wel_ff;
   end

   // Every decision waits for the select rise, so a frame cut short at any other bit does nothing.
   always_comb begin
      go_write_enable_cmd = cs_rise & idle & at_op & (op_ff == OP_WRITE_ENABLE);
      go_blk  = cs_rise & idle & wel_ff & at_addr & is_block_erase(op_ff)
              & ~blk_protected(shift_ff[ADDR_W-1:BLK64_LSB], protect_bits_in, protect_complement_in);
      go_chip = cs_rise & idle & wel_ff & at_op & is_chip_erase(op_ff) & chip_ok;
      go_dp   = cs_rise & idle & at_op & (op_ff == OP_POWER_DOWN);
      go_rel  = cs_rise & (st_ff == ST_DEEP_PD) & (cnt_ff >= 6'(OP_BITS))
              & (op_ff == OP_RELEASE_PD);
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in | s2_ff[0]) begin
         cnt_ff <= 6'h00;
      end else if (sck_rise && cnt_ff != 6'h3F) begin
         cnt_ff <= cnt_ff + 6'h01;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         shift_ff <= 32'h0;
         op_ff    <= 8'h00;
      end else if (sck_rise) begin
         shift_ff <= {shift_ff[30:0], s2_ff[2]};
         if (cnt_ff == 6'(OP_BITS - 1)) begin
            op_ff <= {shift_ff[6:0], s2_ff[2]};
         end
      end
   end

   // Status stays readable while erasing; it is refused in every power-down state.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in | s2_ff[0]) begin
         rbit_ff <= 3'h0;
         moe_ff  <= 1'b0;
         miso_ff <= 1'b0;
      end else if (sck_fall && op_ff == OP_READ_STATUS && cnt_ff >= 6'(OP_BITS)
                   && (idle || st_ff == ST_ERASING)) begin
         miso_ff <= sts[3'h7 - rbit_ff];
         moe_ff  <= 1'b1;
         rbit_ff <= rbit_ff + 3'h1;
      end
   end

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_STANDBY: begin
            if (go_blk || go_chip) begin
               nxt_st = ST_ERASING;
            end else if (go_dp) begin
               nxt_st = ST_DP_ENTRY;
            end
         end
         ST_ERASING: begin
            if (tmr_zero) begin
               nxt_st = ST_STANDBY;
            end
         end
         ST_DP_ENTRY: begin
            if (tmr_zero) begin
               nxt_st = ST_DEEP_PD;
            end
         end
         ST_DEEP_PD: begin
            if (go_rel) begin
               nxt_st = ST_RELEASING;
            end
         end
         ST_RELEASING: begin
            if (tmr_zero) begin
               nxt_st = ST_STANDBY;
            end
         end
         default: begin
            nxt_st = ST_STANDBY;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_ff <= ST_STANDBY;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         tmr_ff <= 32'h0;
      end else if (go_blk) begin
         tmr_ff <= (op_ff == OP_ERASE_32K) ? 32'(BE32_CYC - 1) : 32'(BE64_CYC - 1);
      end else if (go_chip) begin
         tmr_ff <= 32'(CE_CYC - 1);
      end else if (go_dp) begin
         tmr_ff <= 32'(DP_CYC - 1);
      end else if (go_rel) begin
         tmr_ff <= 32'(RES_CYC - 1);
      end else if (!tmr_zero) begin
         tmr_ff <= tmr_ff - 32'h1;
      end
   end

   // The latch is dropped in the first cycle of the erase, well before it ends.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wel_ff <= 1'b0;
      end else if (go_write_enable_cmd) begin
         wel_ff <= 1'b1;
      end else if (st_ff == ST_ERASING) begin
         wel_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         blk64_ff <= 1'b0;
         chip_ff  <= 1'b0;
         blk_ff   <= 9'h000;
      end else if (go_blk || go_chip) begin
         blk64_ff <= (op_ff == OP_ERASE_64K);
         chip_ff  <= go_chip;
         blk_ff   <= shift_ff[ADDR_W-1:BLK32_LSB];
      end
   end

   // Contents before any erase are unknown, so a block counts as erased only after its cycle ends.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         map_ff <= '0;
      end else if (erase_end) begin
         for (int i = 0; i < NUM_BLK32; i++) begin
            if (chip_ff || (9'(i) == blk_ff) || (blk64_ff && (9'(i) >> 1) == (blk_ff >> 1))) begin
               map_ff[i] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         query_erased_out       <= 1'b0;
         write_in_progress_out  <= 1'b0;
         write_enable_latch_out <= 1'b0;
         deep_power_down_out    <= 1'b0;
      end else begin
         query_erased_out       <= map_ff[query_addr_in[ADDR_W-1:BLK32_LSB]];
         write_in_progress_out  <= (nxt_st == ST_ERASING);
         write_enable_latch_out <= wel_ff;
         deep_power_down_out    <= (nxt_st == ST_DEEP_PD);
      end
   end
endmodule : sfe_flash_dev

/* logic/sfe_flash_host.sv */
// Purpose: Controller end that frames erase, power-down and status commands.
// Assumes: One command at a time; the serial clock is divided from ref_clk_in.
// Notes: Erase without a prior write enable is refused locally with no frame.
`timescale 1ns/1ps
module sfe_flash_host #(
   parameter int SCK_HALF = sfe_pkg::SCK_HALF_CYC,
   parameter int DP_WAIT  = sfe_pkg::DP_CYC,
   parameter int RES_WAIT = sfe_pkg::RES_CYC,
   parameter int GAP      = sfe_pkg::GAP_CYC
) (
   input  wire logic                       ref_clk_in,
   input  wire logic                       rst_in,
   sfe_spi_if.host                         spi,
   input  wire logic                       cmd_valid_in,
   input  wire logic [7:0]                 cmd_op_in,
   input  wire logic [sfe_pkg::ADDR_W-1:0] cmd_addr_in,
   output logic                            cmd_ready_out,
   output logic                            rsp_valid_out,
   output logic [7:0]                      rsp_data_out,
   output logic                            rsp_refused_out
);
   import sfe_pkg::*;

   typedef enum logic [1:0] {
      H_IDLE,
      H_SHIFT,
      H_TAIL,
      H_WAIT
   } sfe_host_state_e;

   sfe_host_state_e st_ff;
   sfe_host_state_e nxt_st;
   logic [1:0]      ms_ff;
   logic [7:0]      div_ff;
   logic [5:0]      nb_ff;
   logic [31:0]     tx_ff;
   logic [7:0]      rx_ff;
   logic [7:0]      op_ff;
   logic [31:0]     wait_ff;
   logic            wel_ff;
   logic            cs_ff;
   logic            sck_ff;
   logic            mosi_ff;
   logic            take;
   logic            refuse;
   logic            start;
   logic            half_end;
   logic            full_end;
   logic            tail_end;

   assign spi.cs_n = cs_ff;
   assign spi.sclk = sck_ff;
   assign spi.mosi = mosi_ff;

   always_comb begin
      take     = cmd_valid_in & cmd_ready_out;
      refuse   = take & ~wel_ff & (is_block_erase(cmd_op_in) | is_chip_erase(cmd_op_in));
      start    = take & ~refuse;
      half_end = (st_ff == H_SHIFT) & (div_ff == 8'(SCK_HALF - 1));
      full_end = (st_ff == H_SHIFT) & (div_ff == 8'(2 * SCK_HALF - 1));
      tail_end = (st_ff == H_TAIL) & (div_ff == 8'(SCK_HALF - 1));
      nxt_st   = st_ff;
      case (st_ff)
         H_IDLE:  nxt_st = start ? H_SHIFT : H_IDLE;
         H_SHIFT: nxt_st = (full_end && nb_ff == 6'h01) ? H_TAIL : H_SHIFT;
         H_TAIL:  nxt_st = tail_end ? H_WAIT : H_TAIL;
         H_WAIT:  nxt_st = (wait_ff == 32'h0) ? H_IDLE : H_WAIT;
         default: nxt_st = H_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ms_ff <= 2'h3;
      end else begin
         ms_ff <= {ms_ff[0], spi.miso};
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_ff         <= H_IDLE;
         cmd_ready_out <= 1'b0;
      end else begin
         st_ff         <= nxt_st;
         cmd_ready_out <= (nxt_st == H_IDLE);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in || start || full_end || tail_end) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   // Whole frames only: select rises just after the last bit, so erases and power-down execute.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cs_ff   <= 1'b1;
         sck_ff  <= 1'b0;
         mosi_ff <= 1'b0;
         tx_ff   <= 32'h0;
         nb_ff   <= 6'h00;
         op_ff   <= 8'h00;
      end else if (start) begin
         cs_ff   <= 1'b0;
         mosi_ff <= cmd_op_in[7];
         tx_ff   <= {cmd_op_in, cmd_addr_in};
         op_ff   <= cmd_op_in;
         nb_ff   <= is_block_erase(cmd_op_in) ? 6'(ADDR_CMD_BITS)
                  : (cmd_op_in == OP_READ_STATUS) ? 6'(RDSR_CMD_BITS) : 6'(OP_BITS);
      end else if (half_end) begin
         sck_ff <= 1'b1;
      end else if (full_end) begin
         sck_ff  <= 1'b0;
         nb_ff   <= nb_ff - 6'h01;
         tx_ff   <= {tx_ff[30:0], 1'b0};
         mosi_ff <= tx_ff[30];
      end else if (tail_end) begin
         cs_ff <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rx_ff <= 8'h00;
      end else if (full_end) begin
         rx_ff <= {rx_ff[6:0], ms_ff[1]};
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wait_ff <= 32'h0;
      end else if (tail_end) begin
         wait_ff <= (op_ff == OP_POWER_DOWN) ? 32'(DP_WAIT)
                  : (op_ff == OP_RELEASE_PD) ? 32'(RES_WAIT) : 32'(GAP);
      end else if (wait_ff != 32'h0) begin
         wait_ff <= wait_ff - 32'h1;
      end
   end

   // The shadow latch is a conservative guess; the device clears its own during any erase.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wel_ff <= 1'b0;
      end else if (start && cmd_op_in == OP_WRITE_ENABLE) begin
         wel_ff <= 1'b1;
      end else if (start && (is_block_erase(cmd_op_in) || is_chip_erase(cmd_op_in))) begin
         wel_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rsp_valid_out   <= 1'b0;
         rsp_data_out    <= 8'h00;
         rsp_refused_out <= 1'b0;
      end else begin
         rsp_valid_out   <= tail_end | refuse;
         rsp_refused_out <= refuse;
         rsp_data_out    <= tail_end ? rx_ff : 8'h00;
      end
   end
endmodule : sfe_flash_host

/* tb/sfe_link_chk.sv */
// Purpose: Checks on the serial wires between the flash host and the flash device.
// Assumes: All link signals are sampled on ref_clk_in.
// Notes: A small counter tallies serial clock rises in each frame.
`timescale 1ns/1ps
module sfe_link_chk (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso_drv,
   input wire logic miso_oe,
   input wire logic miso
);
   logic [5:0] bits_ff;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   // The count is cleared while deselected, so it still holds the frame length at the select rise.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || cs_n) begin
         bits_ff <= 6'h00;
      end else if ($rose(sclk)) begin
         bits_ff <= bits_ff + 6'h01;
      end
   end

   property p_frame_len;
      $rose(cs_n) |-> (bits_ff == 6'h08 || bits_ff == 6'h10 || bits_ff == 6'h20);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("Frame length is not 8, 16 or 32 bits.");
   property p_sclk_idle;
      cs_n |-> !sclk;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("Serial clock high while deselected.");
   property p_sclk_hi;
      $rose(sclk) |-> sclk [*4] ##1 !sclk;
   endproperty
   a_sclk_hi: assert property (p_sclk_hi) else $error("Serial clock high phase not 4 cycles.");
   property p_sclk_lo;
      $fell(sclk) |-> !sclk [*4];
   endproperty
   a_sclk_lo: assert property (p_sclk_lo) else $error("Serial clock low phase too short.");
   property p_mosi;
      sclk |-> $stable(mosi);
   endproperty
   a_mosi: assert property (p_mosi) else $error("Serial input moved while clock high.");
   property p_cs_setup;
      $fell(cs_n) |-> !sclk [*3];
   endproperty
   a_cs_setup: assert property (p_cs_setup) else $error("Clock rose too soon after select.");
   property p_cs_gap;
      $rose(cs_n) |-> cs_n [*4];
   endproperty
   a_cs_gap: assert property (p_cs_gap) else $error("Deselect gap shorter than 4 cycles.");
   property p_miso_idle;
      cs_n [*6] |-> !miso_oe;
   endproperty
   a_miso_idle: assert property (p_miso_idle) else $error("Device drives output while deselected.");

   c_frame32: cover property ($rose(cs_n) && bits_ff == 6'h20);
   c_frame16: cover property ($rose(cs_n) && bits_ff == 6'h10);
   c_frame8: cover property ($rose(cs_n) && bits_ff == 6'h08);
   c_drive: cover property (miso_oe);
endmodule : sfe_link_chk

/* tb/test_spi_flash_erase_powerdown.sv */
// Purpose: Self-checking bench for the erase and power-down link, both ends.
// Assumes: Shortened cycle counts; a second device is driven directly by the bench.
// Notes: The second device receives malformed frames that the host never makes.
`timescale 1ns/1ps
module test_spi_flash_erase_powerdown;
   import sfe_pkg::*;
   localparam int E32 = 300;
   localparam int E64 = 400;
   localparam int ECE = 500;
   localparam int LIM = 3000;
   localparam int EDP = 20;
   localparam int HWT = 24;
   typedef struct {
      logic [7:0]  op;
      logic [23:0] addr;
      logic [4:0]  bp;
      logic        cmp;
      logic        run;
      logic [23:0] qa;
      logic        ea;
      logic [23:0] qb;
      logic        eb;
      int          cyc;
   } sfe_row_s;
   logic        clk, rst, cmd_valid, cmd_ready, rsp_valid, rsp_ref, cmp;
   logic        qe, write_in_progress, write_enable_latch, dpd, wip2, wel2, dpd2, ref_seen;
   logic [7:0]  cmd_op, rsp_data, rsp;
   logic [23:0] cmd_addr, qaddr;
   logic [4:0]  bp;
   int          fail_count, num_checks, hi_cnt, n;
   sfe_row_s    rows [7];
   sfe_spi_if spi ();
   sfe_spi_if spi2 ();
   sfe_flash_dev #(.BE32_CYC(E32), .BE64_CYC(E64), .CE_CYC(ECE), .DP_CYC(EDP), .RES_CYC(EDP)) sfe_flash_dev_inst (
      .ref_clk_in(clk), .rst_in(rst), .spi(spi), .protect_bits_in(bp), .protect_complement_in(cmp),
      .query_addr_in(qaddr), .query_erased_out(qe), .write_in_progress_out(write_in_progress),
      .write_enable_latch_out(write_enable_latch), .deep_power_down_out(dpd));
   sfe_flash_dev #(.BE32_CYC(E32), .BE64_CYC(E64), .CE_CYC(ECE), .DP_CYC(EDP), .RES_CYC(EDP)) sfe_flash_dev_inst2 (
      .ref_clk_in(clk), .rst_in(rst), .spi(spi2), .protect_bits_in(bp), .protect_complement_in(cmp),
      .query_addr_in(qaddr), .query_erased_out(), .write_in_progress_out(wip2),
      .write_enable_latch_out(wel2), .deep_power_down_out(dpd2));
   sfe_flash_host #(.DP_WAIT(HWT), .RES_WAIT(HWT)) sfe_flash_host_inst (
      .ref_clk_in(clk), .rst_in(rst), .spi(spi), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op),
      .cmd_addr_in(cmd_addr), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
      .rsp_data_out(rsp_data), .rsp_refused_out(rsp_ref));
   sfe_link_chk sfe_link_chk_inst (
      .ref_clk_in(clk), .rst_in(rst), .cs_n(spi.cs_n), .sclk(spi.sclk), .mosi(spi.mosi),
      .miso_drv(spi.miso_drv), .miso_oe(spi.miso_oe), .miso(spi.miso));

   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) if (write_in_progress === 1'h1) hi_cnt++;

   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic finish_test();
      $display("Checks made %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic bound();
      if (n >= LIM) begin
         fail_count++;
         finish_test();
      end
   endtask : bound
   task automatic do_cmd(input logic [7:0] op, input logic [23:0] a);
      n = 0;
      while (cmd_ready !== 1'h1 && n < LIM) begin tick(); n++; end
      bound();
      cmd_op = op;
      cmd_addr = a;
      cmd_valid = 1'h1;
      tick();
      cmd_valid = 1'h0;
      n = 0;
      while (rsp_valid !== 1'h1 && n < LIM) begin tick(); n++; end
      bound();
      rsp = rsp_data;
      ref_seen = rsp_ref;
      // The device acts a few cycles after its synced select rise, so its outputs need time to settle.
      repeat (6) tick();
   endtask : do_cmd
   // Bits go out MSB first from the top of v; the data line toggles once deselected.
   task automatic raw(input logic [39:0] v, input int nb);
      spi2.cs_n = 1'h0;
      for (int i = 0; i < nb; i++) begin
         spi2.mosi = v[39-i];
         repeat (4) tick();
         spi2.sclk = 1'h1;
         repeat (4) tick();
         spi2.sclk = 1'h0;
      end
      repeat (4) tick();
      spi2.cs_n = 1'h1;
      spi2.mosi = ~spi2.mosi;
      repeat (16) tick();
   endtask : raw
   task automatic qchk(input logic [23:0] a, input logic e);
      qaddr = a;
      repeat (2) tick();
      check(qe, e);
   endtask : qchk

   initial begin
      rst = 1'h1; cmd_valid = 1'h0; cmd_op = 8'h00; cmd_addr = 24'h000000; qaddr = 24'h000000;
      bp = 5'h00; cmp = 1'h0; fail_count = 0; num_checks = 0; hi_cnt = 0;
      spi2.cs_n = 1'h1; spi2.sclk = 1'h0; spi2.mosi = 1'h0;
      rows[0] = '{8'h52, 24'h012345, 5'h00, 1'h0, 1'h1, 24'h010000, 1'h1, 24'h018000, 1'h0, E32};
      rows[1] = '{8'hD8, 24'h20FFFF, 5'h00, 1'h0, 1'h1, 24'h208000, 1'h1, 24'h210000, 1'h0, E64};
      rows[2] = '{8'hD8, 24'hFF0000, 5'h01, 1'h0, 1'h0, 24'hFF8000, 1'h0, 24'h000000, 1'h0, 0};
      rows[3] = '{8'h52, 24'h008000, 5'h09, 1'h0, 1'h0, 24'h008000, 1'h0, 24'h010000, 1'h1, 0};
      rows[4] = '{8'h52, 24'hFF8000, 5'h01, 1'h1, 1'h1, 24'hFFFFFF, 1'h1, 24'hFF0000, 1'h0, E32};
      rows[5] = '{8'hC7, 24'h000000, 5'h00, 1'h1, 1'h0, 24'h7F0000, 1'h0, 24'h7F0000, 1'h0, 0};
      rows[6] = '{8'h60, 24'h000000, 5'h07, 1'h1, 1'h1, 24'h7F0000, 1'h1, 24'h000000, 1'h1, ECE};
      repeat (16) tick();
      rst = 1'h0;
      check(dpd, 1'h0);
      foreach (rows[i]) begin
         bp = rows[i].bp;
         cmp = rows[i].cmp;
         do_cmd(OP_WRITE_ENABLE, 24'h000000);
         check(write_enable_latch, 1'h1);
         hi_cnt = 0;
         do_cmd(rows[i].op, rows[i].addr);
         repeat (8) tick();
         check(write_in_progress, rows[i].run);
         if (rows[i].run) begin
            do_cmd(OP_READ_STATUS, 24'h000000);
            check(rsp, 8'h01);
         end
         n = 0;
         while (write_in_progress === 1'h1 && n < LIM) begin tick(); n++; end
         bound();
         check(32'(hi_cnt >= rows[i].cyc - 1 && hi_cnt <= rows[i].cyc + 2), 32'h1);
         check(write_enable_latch, !rows[i].run);
         qchk(rows[i].qa, rows[i].ea);
         qchk(rows[i].qb, rows[i].eb);
      end
      bp = 5'h00;
      cmp = 1'h0;
      do_cmd(OP_ERASE_32K, 24'h030000);
      check(ref_seen, 1'h1);
      do_cmd(OP_WRITE_ENABLE, 24'h000000);
      do_cmd(OP_ERASE_32K, 24'h030000);
      do_cmd(OP_POWER_DOWN, 24'h000000);
      do_cmd(OP_RELEASE_PD, 24'h000000);
      check(write_in_progress, 1'h1);
      check(dpd, 1'h0);
      n = 0;
      while (write_in_progress === 1'h1 && n < LIM) begin tick(); n++; end
      bound();
      check(dpd, 1'h0);
      qchk(24'h030000, 1'h1);
      do_cmd(OP_POWER_DOWN, 24'h000000);
      check(dpd, 1'h0);
      n = 0;
      while (dpd !== 1'h1 && n < LIM) begin tick(); n++; end
      bound();
      check(dpd, 1'h1);
      do_cmd(OP_WRITE_ENABLE, 24'h000000);
      do_cmd(OP_CHIP_ERASE_B, 24'h000000);
      repeat (8) tick();
      check({write_in_progress, write_enable_latch}, 2'h0);
      do_cmd(OP_READ_STATUS, 24'h000000);
      check(rsp, 8'hFF);
      do_cmd(OP_RELEASE_PD, 24'h000000);
      do_cmd(OP_WRITE_ENABLE, 24'h000000);
      check({dpd, write_enable_latch}, 2'h1);
      raw({OP_CHIP_ERASE_A, 32'h0}, 8);
      check(wip2, 1'h0);
      raw({OP_WRITE_ENABLE, 32'h0}, 8);
      raw({OP_ERASE_32K, 24'h010000, 8'h00}, 31);
      check(wip2, 1'h0);
      raw({OP_ERASE_32K, 24'h010000, 8'h00}, 33);
      check(wip2, 1'h0);
      raw({OP_CHIP_ERASE_B, 32'h0}, 9);
      check({wip2, wel2}, 2'h1);
      raw({OP_POWER_DOWN, 32'h0}, 7);
      repeat (40) tick();
      check(dpd2, 1'h0);
      raw({OP_POWER_DOWN, 32'h0}, 8);
      repeat (40) tick();
      check(dpd2, 1'h1);
      rst = 1'h1;
      repeat (3) tick();
      rst = 1'h0;
      tick();
      check({dpd2, wel2}, 2'h0);
      qchk(24'h7F0000, 1'h0);
      do_cmd(OP_WRITE_ENABLE, 24'h000000);
      do_cmd(OP_ERASE_32K, 24'h03FFFF);
      check(write_in_progress, 1'h1);
      n = 0;
      while (write_in_progress === 1'h1 && n < LIM) begin tick(); n++; end
      bound();
      qchk(24'h038000, 1'h1);
      qchk(24'h030000, 1'h0);
      finish_test();
   end
endmodule : test_spi_flash_erase_powerdown
